// ### rtl/lcs_ctrl.sv
// Low consumption state control: burst stop detection, strap capture,
// duty-qualified exit and settling before gate drive resumes.
// Assumes all inputs synchronous to clk; duty sample valid per switching cycle.
`timescale 1ns/10ps
module lcs_ctrl
	import lcs_pkg::*;
#(
	parameter int unsigned STOP_CNT   = STOP_CYCLES,
	parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Supply and remote enable
	input  wire logic              supply_ok,
	input  wire logic              remote_enable,
	// Drain sense comparators above arming threshold
	input  wire logic [1:0]        drain_sense_inputs,
	// Digitised strap level
	input  wire logic [1:0]        strap_select_pin,
	// Body-diode conduction duty, percent, with valid strobe
	input  wire logic [DUTY_W-1:0] duty_meas,
	input  wire logic              duty_valid,
	// Gate requests from the turn-on/off logic
	input  wire logic [1:0]        gate_req,
	// Outputs
	output logic [1:0]             gate_drive,
	output logic                   strap_sense_current,
	output logic                   low_consumption,
	output logic [DUTY_W-1:0]      exit_duty_threshold
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		lcs_state_t        state;
		logic [CNT_W-1:0]  cnt;
		logic [ACC_W-1:0]  score;
		logic [DUTY_W-1:0] thr;
		logic [1:0]        gate;
		logic              isrc;
		logic              sleep;
	} lcs_regs_t;

	lcs_regs_t         r;
	lcs_regs_t         next_r;
	logic [DUTY_W-1:0] lut_thr;
	logic              both_high;
	logic [DUTY_W-1:0] excess;
	logic              stop_done;
	logic              settle_done;

	// ----------------------------------------------------------------
	// Strap lookup and helpers
	// ----------------------------------------------------------------
	// The lookup is combinational; its value is only kept in the strap phase
	lcs_strap_lut u_lut (
		.strap_code          (strap_select_pin),
		.exit_duty_threshold (lut_thr)
	);

	// Both drains high means the primary has stopped switching
	assign both_high   = &drain_sense_inputs;
	// Excess of measured duty over the held threshold, zero when below it
	assign excess      = (duty_meas > r.thr) ? DUTY_W'(duty_meas - r.thr) : '0;
	// End points of the stop window and of the settling count
	assign stop_done   = (r.cnt >= CNT_W'(STOP_CNT - 1));
	assign settle_done = (r.cnt >= CNT_W'(SETTLE_CNT - 1));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r       = r;
		next_r.gate  = 2'h0;
		// Supply loss drops gates, sense current and count (threshold kept) and forces a fresh strap phase
		if (!supply_ok) begin
			next_r.state = LCS_WAIT_EN;
			next_r.isrc  = 1'b0;
			next_r.sleep = 1'b1;
			next_r.cnt   = '0;
		end else begin
			case (r.state)
				// Wait for enable before the strap is looked at
				LCS_WAIT_EN: begin
					next_r.sleep = 1'b1;
					if (remote_enable) begin
						next_r.state = LCS_STRAP;
						next_r.isrc  = 1'b1;
					end
				end
				// One cycle of sense current, then the code is held
				LCS_STRAP: begin
					next_r.thr   = lut_thr;
					next_r.isrc  = 1'b0;
					next_r.score = '0;
					next_r.state = LCS_QUALIFY;
				end
				// Gates follow their requests; watch for a primary stop
				LCS_RUN: begin
					next_r.sleep = 1'b0;
					next_r.gate  = gate_req;
					if (!remote_enable) begin
						next_r.state = LCS_SLEEP;
						next_r.sleep = 1'b1;
						next_r.gate  = 2'h0;
						next_r.cnt   = '0;
					end else if (both_high) begin
						if (stop_done) begin
							next_r.state = LCS_SLEEP;
							next_r.sleep = 1'b1;
							next_r.gate  = 2'h0;
							next_r.cnt   = '0;
						end else begin
							next_r.cnt = r.cnt + 1'b1;
						end
					end else begin
						next_r.cnt = '0;
					end
				end
				// Idle with gates off until enable is high
				LCS_SLEEP: begin
					next_r.sleep = 1'b1;
					next_r.score = '0;
					if (remote_enable) begin
						next_r.state = LCS_QUALIFY;
					end
				end
				// Excess is accumulated per switching cycle, so a larger
				// excess reaches the exit score in fewer cycles; a sample
				// at or below the threshold starts the count again
				LCS_QUALIFY: begin
					next_r.sleep = 1'b1;
					if (!remote_enable) begin
						next_r.state = LCS_SLEEP;
					end else if (duty_valid) begin
						if (excess == '0) begin
							next_r.score = '0;
						end else if (r.score + ACC_W'(excess) >= EXIT_SCORE) begin
							next_r.state = LCS_SETTLE;
							next_r.cnt   = '0;
						end else begin
							next_r.score = r.score + ACC_W'(excess);
						end
					end
				end
				// Internal timers settle before the gates are released
				LCS_SETTLE: begin
					next_r.sleep = 1'b1;
					if (!remote_enable) begin
						next_r.state = LCS_SLEEP;
					end else if (settle_done) begin
						next_r.state = LCS_RUN;
						next_r.sleep = 1'b0;
						next_r.cnt   = '0;
					end else begin
						next_r.cnt = r.cnt + 1'b1;
					end
				end
				default: begin
					next_r.state = LCS_WAIT_EN;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{state: LCS_WAIT_EN,
			       cnt:   '0,
			       score: '0,
			       thr:   DUTY_OPEN,
			       gate:  2'h0,
			       isrc:  1'b0,
			       sleep: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign gate_drive          = r.gate;
	assign strap_sense_current = r.isrc;
	assign low_consumption     = r.sleep;
	assign exit_duty_threshold = r.thr;
endmodule : lcs_ctrl

// ### inc/lcs_pkg.sv
// Constants and types for the low consumption state control block.
// Assumes a 25 MHz system clock; strap level arrives already digitised.
package lcs_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned STOP_TIME_US  = 20;
	localparam int unsigned STOP_CYCLES   = (STOP_TIME_US * (CLK_HZ / 1000000));
	localparam int unsigned SETTLE_SW_CYC = 12;
	localparam int unsigned SETTLE_CYCLES = SETTLE_SW_CYC * 2;
	localparam int unsigned CNT_W         = 10;
	localparam int unsigned DUTY_W        = 7;
	localparam int unsigned ACC_W         = 12;
	// ----------------------------------------------------------------
	// Strap codes and exit duty thresholds (percent)
	// ----------------------------------------------------------------
	localparam logic [1:0] STRAP_ZERO  = 2'h0;
	localparam logic [1:0] STRAP_100K  = 2'h1;
	localparam logic [1:0] STRAP_180K  = 2'h2;
	localparam logic [1:0] STRAP_OPEN  = 2'h3;
	localparam logic [6:0] DUTY_ZERO   = 7'h50;
	localparam logic [6:0] DUTY_100K   = 7'h4b;
	localparam logic [6:0] DUTY_180K   = 7'h41;
	localparam logic [6:0] DUTY_OPEN   = 7'h00;
	localparam logic [11:0] EXIT_SCORE = 12'h100;
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LCS_WAIT_EN, LCS_STRAP, LCS_RUN, LCS_SLEEP, LCS_QUALIFY, LCS_SETTLE
	} lcs_state_t;
endpackage : lcs_pkg

// ### rtl/lcs_strap_lut.sv
// Strap code to exit duty threshold lookup.
// Pure combinational; the caller registers the result.
`timescale 1ns/10ps
module lcs_strap_lut (
	// Strap code in
	input  wire logic [1:0] strap_code,
	// Threshold out
	output logic [6:0]      exit_duty_threshold
);
	import lcs_pkg::*;
	always_comb begin
		case (strap_code)
			STRAP_ZERO: exit_duty_threshold = DUTY_ZERO;
			STRAP_100K: exit_duty_threshold = DUTY_100K;
			STRAP_180K: exit_duty_threshold = DUTY_180K;
			default:    exit_duty_threshold = DUTY_OPEN;
		endcase
	end
endmodule : lcs_strap_lut

// ### tb/lcs_primary_model.sv
// Primary controller seen through drain senses and duty samples.
// Assumes two clocks per switching cycle.
`timescale 1ns/10ps
module lcs_primary_model (
	input	wire logic	clk,
	input	wire logic	switching,
	input	wire logic [6:0]	duty,
	output	logic [1:0]	drain_sense_inputs,
	output	logic [6:0]	duty_meas,
	output	logic	duty_valid
);
	logic	phase;
	initial begin
		{phase, duty_valid, duty_meas, drain_sense_inputs} = '0;
	end
	// The bench holds one pause shorter than the stop window, then one until sleep
	always @(posedge clk) begin
		phase <= ~phase;
		duty_valid <= switching & phase;
		duty_meas <= (switching & phase) ? duty : ~duty_meas;
		drain_sense_inputs <= switching ? {phase, ~phase} : 2'h3;
	end
endmodule : lcs_primary_model

// ### tb/lcs_ctrl_sva.sv
// Port checker for lcs_ctrl.
// Assumes one clock domain; bound below.
`timescale 1ns/10ps
module lcs_ctrl_sva
	import lcs_pkg::*;
#(
	parameter int unsigned STOP_CNT = STOP_CYCLES,
	parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
	input	wire logic	clk, rst_b, supply_ok, remote_enable, duty_valid,
	input	wire logic [1:0]	drain_sense_inputs, strap_select_pin, gate_req, gate_drive,
	input	wire logic [DUTY_W-1:0]	duty_meas, exit_duty_threshold,
	input	wire logic	strap_sense_current, low_consumption
);
	logic [CNT_W-1:0]	stop_run;
	logic [6:0]	lut;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	assign lut = strap_select_pin == STRAP_ZERO ? DUTY_ZERO : strap_select_pin == STRAP_100K ?
		DUTY_100K : strap_select_pin == STRAP_180K ? DUTY_180K : DUTY_OPEN;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) stop_run <= '0;
		else if (drain_sense_inputs != 2'h3) stop_run <= '0;
		else if (stop_run != '1) stop_run <= stop_run + 1'b1;
	end
	gate_off_a: assert property (low_consumption |-> gate_drive == 2'h0)
		else $error("gate driven while asleep");
	gate_pass_a: assert property (!low_consumption && $past(!low_consumption) |->
		gate_drive == $past(gate_req))
		else $error("gate not passed");
	sense_pulse_a: assert property (strap_sense_current |=> !strap_sense_current)
		else $error("sense current too long");
	thr_lut_a: assert property (strap_sense_current |=> exit_duty_threshold == $past(lut))
		else $error("wrong threshold");
	strap_en_a: assert property ($rose(strap_sense_current) |-> $past(remote_enable))
		else $error("strap sampled while disabled");
	en_off_a: assert property (!low_consumption && !remote_enable |=> low_consumption)
		else $error("enable low ignored");
	stop_min_a: assert property ($rose(low_consumption) |-> stop_run >= STOP_CNT - 1 ||
		!$past(remote_enable) || !$past(supply_ok))
		else $error("early sleep");
	wake_en_a: assert property ($fell(low_consumption) |-> $past(remote_enable))
		else $error("woke while disabled");
	cover property ($rose(low_consumption));
	cover property ($fell(low_consumption));
	cover property (strap_sense_current);
endmodule : lcs_ctrl_sva
bind lcs_ctrl lcs_ctrl_sva #(.STOP_CNT(STOP_CNT), .SETTLE_CNT(SETTLE_CNT)) u_sva (.clk(clk),
	.rst_b(rst_b), .supply_ok(supply_ok), .remote_enable(remote_enable), .duty_valid(duty_valid),
	.drain_sense_inputs(drain_sense_inputs), .strap_select_pin(strap_select_pin),
	.gate_req(gate_req), .gate_drive(gate_drive), .duty_meas(duty_meas),
	.exit_duty_threshold(exit_duty_threshold), .strap_sense_current(strap_sense_current),
	.low_consumption(low_consumption));

// ### tb/low_consumption_state_control_bench.sv
// Bench for lcs_ctrl driven by the primary model.
// Assumes the checker binds itself.
`timescale 1ns/10ps
module low_consumption_state_control_bench;
	import lcs_pkg::*;
	localparam int STOP = 8;
	logic	clk = 1'h0, rst_b = 1'h0, supply_ok = 1'h1, remote_enable = 1'h0, sw = 1'h0;
	logic [1:0]	strap = 2'h0, gate_req = 2'h2, drain, gate_drive;
	logic [6:0]	duty = 7'h5a, duty_meas, thr;
	logic	duty_valid, isrc, lc;
	logic [6:0]	tbl [4] = '{DUTY_ZERO, DUTY_100K, DUTY_180K, DUTY_OPEN};
	int	fails = 0, n_compared = 0, t1, t2, n;
	lcs_ctrl #(.STOP_CNT(STOP), .SETTLE_CNT(SETTLE_CYCLES)) dut (.clk(clk), .rst_b(rst_b),
		.supply_ok(supply_ok), .remote_enable(remote_enable), .drain_sense_inputs(drain),
		.strap_select_pin(strap), .duty_meas(duty_meas), .duty_valid(duty_valid),
		.gate_req(gate_req), .gate_drive(gate_drive), .strap_sense_current(isrc),
		.low_consumption(lc), .exit_duty_threshold(thr));
	lcs_primary_model u_pri (.clk(clk), .switching(sw), .duty(duty),
		.drain_sense_inputs(drain), .duty_meas(duty_meas), .duty_valid(duty_valid));
	initial forever #20 clk = ~clk;
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'h1) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task automatic startup(input int s, input logic late);
		@(posedge clk);
		{rst_b, sw, strap, remote_enable} <= {1'h0, 1'h0, 2'(s), !late};
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		if (late) begin
			step(6);
			chk(isrc === 1'h0, "strap sampled early");
			@(posedge clk);
			remote_enable <= 1'h1;
		end
		for (n = 0; isrc !== 1'h1 && n < 9; n++) step(1);
		chk(isrc === 1'h1, "no strap phase");
		step(1);
		chk(isrc === 1'h0 && thr === tbl[s], "threshold");
	endtask : startup
	task automatic wake(input logic [6:0] d, output int k);
		@(posedge clk);
		{duty, sw} <= {d, 1'h1};
		for (k = 0; lc !== 1'h0 && k < 400; k++) begin
			step(1);
			chk(gate_drive === 2'h0, "gate on asleep");
		end
	endtask : wake
	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		for (int i = 3; i >= 0; i--) startup(i, i == 3);
		wake(7'h5a, t1);
		chk(t1 >= 76 && t1 <= 84, "wake time");
		step(2);
		chk(gate_drive === 2'h2, "gate pass");
		sw <= 1'h0;
		step(STOP - 3);
		sw <= 1'h1;
		step(10);
		chk(lc === 1'h0, "short pause slept");
		sw <= 1'h0;
		for (n = 0; lc !== 1'h1 && n < 50; n++) step(1);
		chk(n >= STOP + 1 && n <= STOP + 3, "stop detect");
		wake(7'h64, t2);
		chk(t1 - t2 >= 24 && t1 - t2 <= 28, "excess scaling");
		remote_enable <= 1'h0;
		step(2);
		chk(lc === 1'h1, "enable low");
		{remote_enable, duty} <= {1'h1, 7'h46};
		step(100);
		chk(lc === 1'h1, "woke below threshold");
		wake(7'h64, n);
		chk(lc === 1'h0, "no resume");
		supply_ok <= 1'h0;
		step(1);
		chk(lc === 1'h1 && gate_drive === 2'h0, "supply loss");
		supply_ok <= 1'h1;
		step(1);
		chk(isrc === 1'h1, "no strap after supply");
		step(1);
		chk(isrc === 1'h0 && thr === DUTY_ZERO, "strap after supply");
		wrap_up();
	end
	initial begin
		#400000;
		fails++;
		wrap_up();
	end
endmodule : low_consumption_state_control_bench
